//--- verilog/smf_ctrl.sv
/*
 SPI control and status block: mode fault, flags, requests, partial reset.
 Assumes register accesses arrive as one-cycle strobes on core_clk_i and
 that a slave link samples on the rising edge of sclk_i (modes 0 and 3).
*/
`timescale 1ns/1ps
module smf_ctrl (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic sclk_i,
	input wire logic ctrl_wr_i,
	input wire logic ctrl_spe_i,
	input wire logic ctrl_master_bit_alias_i,
	input wire logic ctrl_cpol_i,
	input wire logic ctrl_cpha_i,
	input wire logic ctrl_tie_i,
	input wire logic ctrl_rie_i,
	input wire logic stat_wr_i,
	input wire logic stat_mode_fault_enable_i,
	input wire logic stat_error_irq_enable_i,
	input wire logic [1:0] stat_rate_i,
	input wire logic stat_rd_i,
	input wire logic data_wr_i,
	input wire logic [7:0] data_i,
	input wire logic data_rd_i,
	input wire logic wait_i,
	input wire logic stop_i,
	input wire logic ss_n_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	output logic sclk_o,
	output logic sclk_oe_o,
	output logic mosi_o,
	output logic mosi_oe_o,
	output logic miso_o,
	output logic miso_oe_o,
	output logic gpio_ctrl_o,
	output logic spi_enable_o,
	output logic master_select_o,
	output logic transmit_empty_flag_o,
	output logic receive_full_flag_o,
	output logic overrun_flag_o,
	output logic mode_fault_flag_o,
	output logic [7:0] rx_data_o,
	output logic irq_tx_o,
	output logic irq_rx_o,
	output logic wake_o
);
	typedef struct packed {
		logic spi_enable;
		logic master_bit_alias;
		logic cpol;
		logic cpha;
		logic tie;
		logic rie;
		logic mode_fault_enable;
		logic error_irq_enable;
		logic [1:0] rate;
		logic tef;
		logic rxf;
		logic overrun_flag;
		logic mode_fault_flag;
		logic arm_rx;
		logic arm_mode_fault_flag;
		logic [7:0] tdr;
		logic tdr_full;
		logic [7:0] rdr;
		logic [7:0] tx_hold;
		logic ss_s1;
		logic ss_s2;
		logic ss_prev;
		logic miso_s1;
		logic miso_s2;
		logic [2:0] tg_s1;
		logic [2:0] tg_s2;
		logic [2:0] tg_prev;
		logic slv_act;
		logic slv_en;
		logic m_busy;
		logic [6:0] m_div;
		logic [4:0] m_edge;
		logic [7:0] m_sh;
		logic m_sclk;
		logic m_mosi;
		logic pin_m;
		logic pin_s;
		logic gpio;
		logic irq_tx;
		logic irq_rx;
		logic wake;
	} smf_core_t;

	smf_core_t cur_ff, nxt_ff;
	logic lnk_rst_n;
	logic [2:0] l_cnt_ff;
	logic [7:0] l_sh_ff;
	logic [7:0] l_rx_ff;
	logic [2:0] l_tg_ff;

	function automatic logic [6:0] half_period(input logic [1:0] rate);
		unique case (rate)
			2'h0: half_period = smf_pkg::SMF_HALF_DIV2;
			2'h1: half_period = smf_pkg::SMF_HALF_DIV8;
			2'h2: half_period = smf_pkg::SMF_HALF_DIV32;
			2'h3: half_period = smf_pkg::SMF_HALF_DIV128;
		endcase
	endfunction

	// ====================================================================
	// Link domain: slave shift path clocked by the incoming serial clock
	// ====================================================================
	// Deselect or disable holds the bit counter at zero
	assign lnk_rst_n = resetn_i & ~ss_n_i & cur_ff.slv_en;

	// Bit counter and shifter, cleared while deselected
	always_ff @(posedge sclk_i or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			l_cnt_ff <= 3'h0;
			l_sh_ff <= 8'h00;
		end else begin
			l_cnt_ff <= l_cnt_ff + 3'h1;
			if (l_cnt_ff == 3'h0) begin
				l_sh_ff <= {cur_ff.tx_hold[6:0], mosi_i};
			end else begin
				l_sh_ff <= {l_sh_ff[6:0], mosi_i};
			end
		end
	end

	// Event toggles and received byte, kept across deselect
	always_ff @(posedge sclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			l_tg_ff <= 3'h0;
			l_rx_ff <= 8'h00;
		end else begin
			if (l_cnt_ff == 3'h0) begin
				l_tg_ff[smf_pkg::SMF_EV_START] <= ~l_tg_ff[smf_pkg::SMF_EV_START];
			end
			if (l_cnt_ff == smf_pkg::SMF_CNT_BIT1) begin
				l_tg_ff[smf_pkg::SMF_EV_BIT1] <= ~l_tg_ff[smf_pkg::SMF_EV_BIT1];
			end
			if (l_cnt_ff == smf_pkg::SMF_CNT_LAST) begin
				l_rx_ff <= {l_sh_ff[6:0], mosi_i};
				l_tg_ff[smf_pkg::SMF_EV_DONE] <= ~l_tg_ff[smf_pkg::SMF_EV_DONE];
			end
		end
	end

	// ====================================================================
	// Core domain
	// ====================================================================
	always_comb begin
		logic [2:0] ev;
		logic acc;
		logic m_fault;
		logic s_fault;
		logic ss_fall;
		logic ss_rise;
		logic tick;
		logic samp;
		logic set_tef;
		logic set_rxf;
		logic set_ovr;
		logic [7:0] rx_byte;
		ev = cur_ff.tg_s2 ^ cur_ff.tg_prev;
		acc = ~wait_i;
		ss_fall = cur_ff.ss_prev & ~cur_ff.ss_s2;
		ss_rise = ~cur_ff.ss_prev & cur_ff.ss_s2;
		tick = 1'b0;
		samp = 1'b0;
		set_tef = 1'b0;
		set_rxf = 1'b0;
		set_ovr = 1'b0;
		rx_byte = l_rx_ff;
		nxt_ff = cur_ff;
		// Synchronisers for select, master input and link toggles
		nxt_ff.ss_s1 = ss_n_i;
		nxt_ff.ss_s2 = cur_ff.ss_s1;
		nxt_ff.ss_prev = cur_ff.ss_s2;
		nxt_ff.miso_s1 = miso_i;
		nxt_ff.miso_s2 = cur_ff.miso_s1;
		nxt_ff.tg_s1 = l_tg_ff;
		nxt_ff.tg_s2 = cur_ff.tg_s1;
		nxt_ff.tg_prev = cur_ff.tg_s2;
		// Mode fault conditions
		m_fault = cur_ff.spi_enable & cur_ff.master_bit_alias & cur_ff.mode_fault_enable & ~cur_ff.ss_s2;
		s_fault = cur_ff.spi_enable & ~cur_ff.master_bit_alias & cur_ff.mode_fault_enable & cur_ff.slv_act & ss_rise;
		// Register writes; controls are kept by the partial reset
		if (acc && ctrl_wr_i) begin
			nxt_ff.spi_enable = ctrl_spe_i;
			nxt_ff.master_bit_alias = ctrl_master_bit_alias_i;
			nxt_ff.cpol = ctrl_cpol_i;
			nxt_ff.cpha = ctrl_cpha_i;
			nxt_ff.tie = ctrl_tie_i;
			nxt_ff.rie = ctrl_rie_i;
		end
		if (acc && stat_wr_i) begin
			nxt_ff.mode_fault_enable = stat_mode_fault_enable_i;
			nxt_ff.error_irq_enable = stat_error_irq_enable_i;
			nxt_ff.rate = stat_rate_i;
		end
		if (acc && data_wr_i) begin
			nxt_ff.tdr = data_i;
			nxt_ff.tdr_full = 1'b1;
			nxt_ff.tef = 1'b0;
		end
		// Slave transfer tracking
		if (!cur_ff.cpha && ss_fall) begin
			nxt_ff.slv_act = 1'b1;
		end
		if (cur_ff.cpha && ev[smf_pkg::SMF_EV_START]) begin
			nxt_ff.slv_act = 1'b1;
		end
		if (ev[smf_pkg::SMF_EV_DONE] || cur_ff.ss_s2) begin
			nxt_ff.slv_act = 1'b0;
		end
		// Slave transmit byte moves to the link holding register
		if (!cur_ff.master_bit_alias && cur_ff.tdr_full && (cur_ff.ss_s2 || ev[smf_pkg::SMF_EV_DONE])) begin
			// A write in the same cycle queues the new byte behind this one
			nxt_ff.tx_hold = cur_ff.tdr;
			nxt_ff.tdr_full = acc & data_wr_i;
			set_tef = ~(acc & data_wr_i);
		end
		if (!cur_ff.master_bit_alias && ev[smf_pkg::SMF_EV_BIT1] && cur_ff.rxf) begin
			set_ovr = 1'b1;
		end
		if (!cur_ff.master_bit_alias && ev[smf_pkg::SMF_EV_DONE]) begin
			set_rxf = 1'b1;
		end
		// Master engine, frozen in stop
		if (cur_ff.spi_enable && cur_ff.master_bit_alias && !stop_i) begin
			if (!cur_ff.m_busy && cur_ff.tdr_full) begin
				nxt_ff.m_busy = 1'b1;
				nxt_ff.m_sh = cur_ff.tdr;
				nxt_ff.m_mosi = cur_ff.tdr[7];
				nxt_ff.tdr_full = acc & data_wr_i;
				nxt_ff.m_div = half_period(cur_ff.rate);
				nxt_ff.m_edge = 5'h00;
				set_tef = ~(acc & data_wr_i);
			end else if (cur_ff.m_busy) begin
				nxt_ff.m_div = cur_ff.m_div - 7'h01;
				tick = (cur_ff.m_div == 7'h01);
			end
		end
		if (tick) begin
			nxt_ff.m_div = half_period(cur_ff.rate);
			nxt_ff.m_sclk = ~cur_ff.m_sclk;
			nxt_ff.m_edge = cur_ff.m_edge + 5'h01;
			samp = (cur_ff.m_edge[0] == cur_ff.cpha);
			if (samp) begin
				nxt_ff.m_sh = {cur_ff.m_sh[6:0], cur_ff.miso_s2};
				if (cur_ff.m_edge[4:1] == smf_pkg::SMF_SAMPLE_BIT1 && cur_ff.rxf) begin
					set_ovr = 1'b1;
				end
			end else begin
				nxt_ff.m_mosi = cur_ff.m_sh[7];
			end
			if (cur_ff.m_edge == smf_pkg::SMF_EDGE_LAST) begin
				nxt_ff.m_busy = 1'b0;
				set_rxf = 1'b1;
				rx_byte = samp ? {cur_ff.m_sh[6:0], cur_ff.miso_s2} : cur_ff.m_sh;
			end
		end
		if (!cur_ff.m_busy) begin
			nxt_ff.m_sclk = cur_ff.cpol;
		end
		// Two-step clears; a set in the same cycle wins
		if (acc && stat_rd_i) begin
			nxt_ff.arm_rx = cur_ff.rxf | cur_ff.overrun_flag;
			nxt_ff.arm_mode_fault_flag = cur_ff.mode_fault_flag;
		end
		if (acc && data_rd_i && cur_ff.arm_rx) begin
			nxt_ff.rxf = 1'b0;
			nxt_ff.overrun_flag = 1'b0;
			nxt_ff.arm_rx = 1'b0;
		end
		if (acc && ctrl_wr_i && cur_ff.arm_mode_fault_flag && !m_fault && !s_fault) begin
			nxt_ff.mode_fault_flag = 1'b0;
			nxt_ff.arm_mode_fault_flag = 1'b0;
		end
		if (m_fault || s_fault) begin
			nxt_ff.arm_mode_fault_flag = 1'b0;
		end
		if (set_ovr) begin
			nxt_ff.overrun_flag = 1'b1;
		end
		if (set_rxf && !cur_ff.overrun_flag && !set_ovr) begin
			nxt_ff.rdr = rx_byte;
			nxt_ff.rxf = 1'b1;
		end
		if (set_tef) begin
			nxt_ff.tef = 1'b1;
		end
		// Mode fault; the master case also disables the block
		if (m_fault || s_fault) begin
			nxt_ff.mode_fault_flag = 1'b1;
		end
		if (m_fault) begin
			nxt_ff.spi_enable = 1'b0;
		end
		// Partial reset whenever the block is disabled
		if (!nxt_ff.spi_enable) begin
			nxt_ff.tef = 1'b1;
			nxt_ff.m_busy = 1'b0;
			nxt_ff.m_sh = 8'h00;
			nxt_ff.m_edge = 5'h00;
			nxt_ff.m_sclk = nxt_ff.cpol;
			nxt_ff.slv_act = 1'b0;
			nxt_ff.tdr_full = 1'b0;
		end
		// Pin ownership: master select matters only while enabled
		nxt_ff.pin_m = nxt_ff.spi_enable & nxt_ff.master_bit_alias;
		nxt_ff.pin_s = nxt_ff.spi_enable & ~nxt_ff.master_bit_alias & ~cur_ff.ss_s2;
		nxt_ff.slv_en = nxt_ff.spi_enable & ~nxt_ff.master_bit_alias;
		nxt_ff.gpio = ~nxt_ff.spi_enable;
		// Requests, also usable as wake sources in wait
		nxt_ff.irq_tx = nxt_ff.tef & nxt_ff.tie & nxt_ff.spi_enable;
		nxt_ff.irq_rx = (nxt_ff.rxf & nxt_ff.rie) |
			((nxt_ff.overrun_flag | nxt_ff.mode_fault_flag) & nxt_ff.error_irq_enable);
		nxt_ff.wake = nxt_ff.irq_tx | nxt_ff.irq_rx;
	end

	// Core state register; system reset clears controls and flags, sets tef
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur_ff <= '0;
			cur_ff.tef <= smf_pkg::SMF_TX_EMPTY_RST;
			cur_ff.ss_s1 <= 1'b1;
			cur_ff.ss_s2 <= 1'b1;
			cur_ff.ss_prev <= 1'b1;
			cur_ff.gpio <= 1'b1;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// ====================================================================
	// Outputs
	// ====================================================================
	assign sclk_o = cur_ff.m_sclk;
	assign sclk_oe_o = cur_ff.pin_m;
	assign mosi_o = cur_ff.m_mosi;
	assign mosi_oe_o = cur_ff.pin_m;
	// First slave bit comes from the holding register before any edge
	assign miso_o = (l_cnt_ff == 3'h0) ? cur_ff.tx_hold[7] : l_sh_ff[7];
	assign miso_oe_o = cur_ff.pin_s;
	assign gpio_ctrl_o = cur_ff.gpio;
	assign spi_enable_o = cur_ff.spi_enable;
	assign master_select_o = cur_ff.master_bit_alias;
	assign transmit_empty_flag_o = cur_ff.tef;
	assign receive_full_flag_o = cur_ff.rxf;
	assign overrun_flag_o = cur_ff.overrun_flag;
	assign mode_fault_flag_o = cur_ff.mode_fault_flag;
	assign rx_data_o = cur_ff.rdr;
	assign irq_tx_o = cur_ff.irq_tx;
	assign irq_rx_o = cur_ff.irq_rx;
	assign wake_o = cur_ff.wake;

	// ====================================================================
	// Assertions
	// ====================================================================
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	a_mode_fault_flag_needs_en: assert property ($rose(cur_ff.mode_fault_flag) |-> $past(cur_ff.mode_fault_enable))
		else $error("Mode fault set without fault enable");
	a_master_fault_off: assert property ($rose(cur_ff.mode_fault_flag) && $past(cur_ff.master_bit_alias)
		|-> !cur_ff.spi_enable && cur_ff.tef && cur_ff.gpio)
		else $error("Master fault left block enabled");
	a_master_bit_alias_kept: assert property ($rose(cur_ff.mode_fault_flag) |-> $stable(cur_ff.master_bit_alias))
		else $error("Fault changed master select");
	a_slave_fault_on: assert property ($rose(cur_ff.mode_fault_flag) && !$past(cur_ff.master_bit_alias)
		|-> $stable(cur_ff.spi_enable))
		else $error("Slave fault changed enable");
	a_tx_req: assert property (irq_tx_o |-> cur_ff.spi_enable && cur_ff.tie && cur_ff.tef)
		else $error("Transmit request while not allowed");
	a_err_req: assert property (cur_ff.mode_fault_flag && cur_ff.error_irq_enable ##1 cur_ff.mode_fault_flag && cur_ff.error_irq_enable
		|-> irq_rx_o)
		else $error("Fault did not raise error request");
	a_disabled_empty: assert property (!cur_ff.spi_enable |-> cur_ff.tef && !cur_ff.m_busy)
		else $error("Disabled block not in partial reset");
	a_rx_blocked: assert property (cur_ff.overrun_flag && !data_rd_i |=> $stable(cur_ff.rdr))
		else $error("Receive register loaded during overrun");
	a_tef_write: assert property (data_wr_i && !wait_i && !ctrl_wr_i && cur_ff.spi_enable
		&& !cur_ff.tdr_full && !(cur_ff.master_bit_alias && cur_ff.mode_fault_enable && !cur_ff.ss_s2)
		|=> !cur_ff.tef)
		else $error("Data write left transmit empty set");
	a_no_access_wait: assert property (wait_i && ctrl_wr_i |=> $stable(cur_ff.cpha))
		else $error("Register written in wait");

	c_master_byte: cover property (cur_ff.m_busy ##[1:300] !cur_ff.m_busy && cur_ff.rxf);
	c_master_fault: cover property (cur_ff.master_bit_alias && $rose(cur_ff.mode_fault_flag));
	c_slave_byte: cover property (!cur_ff.master_bit_alias && $rose(cur_ff.rxf));
	c_overrun: cover property ($rose(cur_ff.overrun_flag));
endmodule

//--- shared/smf_pkg.sv
/*
 Constants shared by the SPI control and status block.
 Assumes a 20 MHz core clock and a byte-wide shift path.
*/
package smf_pkg;
	localparam int SMF_BYTE_W = 8;
	localparam logic [2:0] SMF_CNT_BIT1 = 3'h6;
	localparam logic [2:0] SMF_CNT_LAST = 3'h7;
	localparam logic [3:0] SMF_SAMPLE_BIT1 = 4'h6;
	localparam logic [4:0] SMF_EDGE_LAST = 5'h0f;
	localparam logic [6:0] SMF_HALF_DIV2 = 7'h01;
	localparam logic [6:0] SMF_HALF_DIV8 = 7'h04;
	localparam logic [6:0] SMF_HALF_DIV32 = 7'h10;
	localparam logic [6:0] SMF_HALF_DIV128 = 7'h40;
	localparam logic SMF_TX_EMPTY_RST = 1'b1;
	// Toggle indices of link events
	localparam int SMF_EV_START = 0;
	localparam int SMF_EV_BIT1 = 1;
	localparam int SMF_EV_DONE = 2;
	localparam int SMF_EV_N = 3;
endpackage

//--- tb/smf_remote.sv
/*
 Remote SPI master model that drives the link pins of the slave port.
 Assumes the testbench calls send or sel; modes 0 and 3 only.
*/
`timescale 1ns/1ps
module smf_remote (
	input wire logic miso_i,
	output logic ss_n_o,
	output logic sclk_o,
	output logic mosi_o,
	output logic [7:0] got_o
);
	// ==========================================
	// Idle pins
	initial begin
		ss_n_o = 1'b1;
		sclk_o = 1'b1;
		mosi_o = 1'b0;
		got_o = 8'h00;
	end

	// ==========================================
	// One byte frame, MSB first; clock stands still outside it
	task automatic send(input logic [7:0] b, input logic m3);
		int i;
		#13;
		sclk_o = m3;
		ss_n_o = 1'b0;
		#80;
		for (i = 7; i >= 0; i--) begin
			sclk_o = 1'b0;
			mosi_o = b[i];
			#80;
			sclk_o = 1'b1;
			got_o = {got_o[6:0], miso_i};
			#80;
			sclk_o = m3;
		end
		#80;
		ss_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released line shows no stale bit
	endtask

	// ==========================================
	// Select and deselect with no clock
	task automatic sel();
		ss_n_o = 1'b0;
		#400;
		ss_n_o = 1'b1;
		#400;
	endtask
endmodule

//--- tb/tb.sv
/*
 Self-checking bench of the SPI control block: master loopback, slave
 frames from the remote model, faults, flag clears, requests and wait.
 Assumes smf_remote is compiled first.
*/
`timescale 1ns/1ps
module tb;
	logic clk, rstn, ctrl_wr, stat_wr, stat_rd, data_wr, data_rd, wait_s, tb_ss, stop_s;
	logic [5:0] cv;
	logic [3:0] sv;
	logic [7:0] din, rx, got;
	logic sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, gpio, spi_enable, master_bit_alias;
	logic tef, rxf, overrun_flag, mode_fault_flag, irq_tx, irq_rx, wake, r_ss, r_sclk, r_mosi;
	int num_errors = 0;
	int tests_run = 0;
	wire miso_w = miso_oe ? miso : 1'bz;

	smf_ctrl uut (.core_clk_i(clk), .resetn_i(rstn), .sclk_i(r_sclk), .ctrl_wr_i(ctrl_wr),
		.ctrl_spe_i(cv[5]), .ctrl_master_bit_alias_i(cv[4]), .ctrl_cpol_i(cv[3]), .ctrl_cpha_i(cv[2]),
		.ctrl_tie_i(cv[1]), .ctrl_rie_i(cv[0]), .stat_wr_i(stat_wr), .stat_mode_fault_enable_i(sv[3]),
		.stat_error_irq_enable_i(sv[2]), .stat_rate_i(sv[1:0]), .stat_rd_i(stat_rd),
		.data_wr_i(data_wr), .data_i(din), .data_rd_i(data_rd), .wait_i(wait_s),
		.stop_i(stop_s), .ss_n_i(r_ss & tb_ss), .mosi_i(r_mosi), .miso_i(mosi),
		.sclk_o(sclk), .sclk_oe_o(sclk_oe), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
		.miso_o(miso), .miso_oe_o(miso_oe), .gpio_ctrl_o(gpio), .spi_enable_o(spi_enable),
		.master_select_o(master_bit_alias), .transmit_empty_flag_o(tef), .receive_full_flag_o(rxf),
		.overrun_flag_o(overrun_flag), .mode_fault_flag_o(mode_fault_flag), .rx_data_o(rx),
		.irq_tx_o(irq_tx), .irq_rx_o(irq_rx), .wake_o(wake));

	smf_remote rm (.miso_i(miso_w), .ss_n_o(r_ss), .sclk_o(r_sclk), .mosi_o(r_mosi),
		.got_o(got));

	// ==========================================
	// Clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================
	// Helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One-cycle strobe: 0 control, 1 status write, 2 status read, 3 data write, 4 data read
	task automatic strobe(input int k);
		case (k)
			0: ctrl_wr = 1'b1;
			1: stat_wr = 1'b1;
			2: stat_rd = 1'b1;
			3: data_wr = 1'b1;
			default: data_rd = 1'b1;
		endcase
		tick(1);
		{ctrl_wr, stat_wr, stat_rd, data_wr, data_rd} = 5'h00;
	endtask

	task automatic ctrl_w(input logic [5:0] v);
		cv = v;
		strobe(0);
		tick(1);
	endtask

	task automatic conclude();
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		int n;
		int ns;
		logic sp;
		{rstn, ctrl_wr, stat_wr, stat_rd, data_wr, data_rd, wait_s, stop_s} = 8'h00;
		{cv, sv, din, tb_ss} = 19'h00001;
		repeat (8) @(posedge clk);
		#5;
		rstn = 1'b1;
		tick(1);
		chk("reset", 8'h41, {spi_enable, tef, rxf, overrun_flag, mode_fault_flag, irq_tx, irq_rx, gpio});
		// Master with fault detection, error requests, rate 1
		sv = 4'hd;
		strobe(1);
		ctrl_w(6'h33);
		chk("master pins", 8'h06, {gpio, sclk_oe, mosi_oe, miso_oe});
		chk("tx request", 8'h01, irq_tx);
		din = 8'ha5;
		strobe(3);
		chk("tef cleared", 8'h00, tef);
		// Stop holds the queued byte; the engine must not start
		stop_s = 1'b1;
		tick(20);
		chk("stop held", 8'h00, {rxf, tef, sclk});
		stop_s = 1'b0;
		ns = 0;
		sp = sclk;
		for (n = 0; n < 600 && rxf !== 1'b1; n++) begin
			tick(1);
			if (sclk && !sp) begin
				ns++;
			end
			sp = sclk;
		end
		if (n == 600) begin
			num_errors++;
			conclude();
		end
		tick(1);
		chk("master clocks", 8'h08, ns[7:0]);
		chk("master rx", 8'ha5, rx);
		chk("tef set", 8'h01, tef);
		chk("rx request", 8'h01, irq_rx);
		strobe(2);
		strobe(4);
		tick(1);
		chk("rxf clear", 8'h00, rxf);
		// Master mode fault
		tb_ss = 1'b0;
		tick(5);
		chk("master fault", 8'h17, {mode_fault_flag, spi_enable, tef, master_bit_alias, gpio});
		chk("fault req", 8'h01, {irq_tx, irq_rx});
		// Re-enabling as master with select still low faults again at once
		strobe(2);
		ctrl_w(6'h33);
		chk("clear blocked", 8'h02, {mode_fault_flag, spi_enable});
		tb_ss = 1'b1;
		tick(4);
		strobe(2);
		ctrl_w(6'h2c);
		chk("clear done", 8'h00, {mode_fault_flag, master_bit_alias});
		// Slave mode 3
		chk("slave float", 8'h00, miso_oe);
		din = 8'h3c;
		strobe(3);
		rm.send(8'h96, 1'b1);
		tick(2);
		chk("slave rx", 8'h96, rx);
		chk("slave tx", 8'h3c, got);
		chk("slave flags", 8'h08, {rxf, overrun_flag, mode_fault_flag, irq_rx});
		rm.send(8'h69, 1'b1);
		tick(2);
		chk("overrun", 8'h96, rx);
		chk("ovr flags", 8'h0d, {rxf, overrun_flag, mode_fault_flag, irq_rx});
		wait_s = 1'b1;
		tick(2);
		chk("wake", 8'h01, wake);
		cv = 6'h00;
		strobe(0);
		strobe(2);
		wait_s = 1'b0;
		strobe(4);
		tick(1);
		chk("wait refuse", 8'h01, overrun_flag);
		chk("wait ctrl", 8'h01, spi_enable);
		strobe(2);
		strobe(4);
		tick(1);
		chk("ovr clear", 8'h00, {rxf, overrun_flag});
		rm.sel();
		tick(4);
		chk("cpha1 pulse", 8'h00, mode_fault_flag);
		// Slave mode 0
		ctrl_w(6'h20);
		rm.send(8'h5a, 1'b0);
		tick(4);
		chk("cpha0 frame", 8'h5a, rx);
		chk("cpha0 end", 8'h00, mode_fault_flag);
		rm.sel();
		tick(4);
		chk("cpha0 pulse", 8'h03, {mode_fault_flag, spi_enable});
		sv = 4'h5;
		strobe(1);
		tick(1);
		chk("mode_fault_flag kept", 8'h01, mode_fault_flag);
		strobe(2);
		ctrl_w(6'h20);
		rm.sel();
		tick(4);
		chk("mode_fault_flag blocked", 8'h00, mode_fault_flag);
		ctrl_w(6'h00);
		chk("disable", 8'h03, {tef, gpio});
		conclude();
	end
endmodule
